// ---- common/edpa_pkg.sv ----
/*
 File: shared constants and types for the Ethernet DMA poll/arbitration
 control block.
 Assumes: AXI4-Lite register bus with 32-bit data, one clock, sync reset.
*/
// Function
// - Next unchained descriptor address adds gap field words after current one.
// - Gap counts from end of current descriptor to start of next.
// - Gap zero in ring mode means descriptors packed back to back.
// - Select bit 0 gives weighted round-robin; tx-first picks heavier side.
// - Select bit 1 gives fixed priority; tx-first picks the winner.
// - Soft reset bit resets DMA and MAC state; reads 1 after reset.
// - Soft reset bit self-clears only after all reset work finishes.
// - Any write to tx poll makes tx DMA fetch current tx descriptor; code fetches on poll only while tx is suspended.
// - Host-owned tx descriptor keeps tx suspended, sets status bit 2.
// - DMA-owned tx descriptor ends suspend and resumes transmission.
// - Tx enters suspend on underflow or when no owned descriptor exists.
// - Tx poll accepted anytime; pending poll drops when refetch begins.
// - Tx poll register always reads zero.
// - Any write to rx poll makes rx DMA fetch current rx descriptor; code fetches on poll only while rx is suspended.
// - Host-owned rx descriptor keeps rx suspended, sets bit 7; else resume.
// - Rx suspends with no owned descriptor, stays until rx poll written.
// - Ratio field 00,01,10,11 mean weights 1:1,2:1,3:1,4:1.
package edpa_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_BUS_MODE = 8'h00;
   localparam logic [7:0] OFF_TX_POLL = 8'h04;
   localparam logic [7:0] OFF_RX_POLL = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_INT_MASK = 8'h1c;
   localparam logic [7:0] OFF_CUR_TX = 8'h48;
   localparam logic [7:0] OFF_CUR_RX = 8'h4c;
   localparam logic [7:0] OFF_DESC_CTL = 8'h50;
   // Bus mode fields
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_ARB_SELECT = 1;
   localparam int GAP_LSB = 2;
   localparam int GAP_MSB = 6;
   localparam int RATIO_LSB = 14;
   localparam int RATIO_MSB = 15;
   localparam int BIT_TX_FIRST = 27;
   localparam logic [31:0] BUS_MODE_RST = 32'h0000_0001;
   // Status fields
   localparam int BIT_TX_BUF_UNAVAIL = 2;
   localparam int BIT_RX_BUF_UNAVAIL = 7;
   localparam int BIT_TX_UNDERFLOW = 5;
   localparam logic [31:0] STATUS_MASK = 32'h0000_00a4;
   // Descriptor size in bytes and reset duration
   localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
   localparam int RESET_NS = 640;
   localparam int CLK_NS = 40;
   localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef struct packed {
      logic tx_first_bit;
      logic [1:0] rx_tx_weight_ratio;
      logic [4:0] descriptor_gap_words;
      logic arbitration_select;
   } edpa_mode_t;

   // Descriptor fetch request and answer from host memory
   typedef struct packed {
      logic valid;
      logic is_rx;
      logic [31:0] addr;
   } edpa_fetch_t;

   typedef struct packed {
      logic valid;
      logic dma_owned;
      logic chained;
   } edpa_fetch_ans_t;
endpackage

// ---- verilog/edpa_arbiter.sv ----
/*
 File: transmit/receive grant arbiter, weighted round-robin or fixed.
 Assumes: requests held until granted; one grant per cycle accepted.
*/
`timescale 1ns/100ps
module edpa_arbiter (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Configuration
   input wire edpa_pkg::edpa_mode_t i_mode,
   // Requests and grants
   input wire logic i_tx_req,
   input wire logic i_rx_req,
   input wire logic i_take,
   output logic o_tx_gnt,
   output logic o_rx_gnt
);
   logic [2:0] credit_r;
   logic fav_turn_r;
   logic fav_req, oth_req, pick_fav;

   always_comb begin
      fav_req = i_mode.tx_first_bit ? i_tx_req : i_rx_req;
      oth_req = i_mode.tx_first_bit ? i_rx_req : i_tx_req;
      if (i_mode.arbitration_select) begin
         pick_fav = fav_req;
      end else begin
         pick_fav = fav_req && (fav_turn_r || !oth_req);
      end
      o_tx_gnt = i_mode.tx_first_bit ? pick_fav : (oth_req && !pick_fav);
      o_rx_gnt = i_mode.tx_first_bit ? (oth_req && !pick_fav) : pick_fav;
   end

   // Favoured side gets ratio+1 grants per one grant of the other side
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         credit_r <= 3'h0;
         fav_turn_r <= 1'b1;
      end else if (i_take && (fav_req || oth_req)) begin
         if (pick_fav) begin
            if (credit_r >= {1'b0, i_mode.rx_tx_weight_ratio}) begin
               credit_r <= 3'h0;
               fav_turn_r <= 1'b0;
            end else begin
               credit_r <= credit_r + 3'h1;
            end
         end else begin
            credit_r <= 3'h0;
            fav_turn_r <= 1'b1;
         end
      end
   end
endmodule

// ---- verilog/edpa_ctrl.sv ----
/*
 File: Ethernet DMA control top: registers, soft reset, poll demand,
 suspend tracking, next-descriptor address and fetch arbitration.
 Assumes: AXI4-Lite master from host; host memory answers descriptor
 fetches on o_fetch/i_fetch_ans; MAC reports underflow and descriptor
 completion as one-cycle pulses.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module edpa_ctrl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // AXI4-Lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // AXI4-Lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Descriptor fetch to host memory
   output edpa_pkg::edpa_fetch_t o_fetch,
   input wire edpa_pkg::edpa_fetch_ans_t i_fetch_ans,
   // Events from the MAC datapath
   input wire logic i_tx_underflow,
   input wire logic i_tx_desc_done,
   input wire logic i_rx_desc_done,
   input wire logic i_mac_reset_busy,
   // Reset to DMA and MAC logic, interrupt
   output logic o_dma_mac_reset,
   output logic o_irq
);
   typedef enum logic [1:0] {EDPA_RUN, EDPA_FETCH, EDPA_SUSP} edpa_st_t;

   edpa_pkg::edpa_mode_t mode_r;
   logic soft_reset_r;
   logic [4:0] rst_cnt_r;
   logic [31:0] status_r, mask_r;
   logic [31:0] current_tx_descriptor_ptr_r, current_rx_descriptor_ptr_r;
   logic [31:0] tx_base_r, rx_base_r;
   logic tx_ring_end_r, rx_ring_end_r;
   logic tx_poll_value_r, rx_poll_value_r;
   edpa_st_t tx_st_r, rx_st_r;
   logic busy_r, busy_rx_r;
   logic [31:0] set_bits;
   logic aw_got_r, w_got_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire, rd_fire;
   logic tx_req, rx_req, tx_gnt, rx_gnt, dma_rst;

   // Next descriptor: end of current plus gap words, or list base at ring end
   function automatic logic [31:0] next_desc(input logic [31:0] cur,
         input logic [4:0] gap, input logic chained, input logic wrap,
         input logic [31:0] base);
      if (wrap) begin
         next_desc = base;
      end else if (chained) begin
         next_desc = cur + edpa_pkg::DESC_BYTES;
      end else begin
         next_desc = cur + edpa_pkg::DESC_BYTES + {25'h0, gap, 2'b00};
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   assign dma_rst = i_srst || soft_reset_r;
   assign o_dma_mac_reset = soft_reset_r;
   assign o_irq = |(status_r & mask_r);

   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
   assign s_axi_wready = !w_got_r && !s_axi_bvalid;
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= edpa_pkg::AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_r)
               edpa_pkg::OFF_BUS_MODE, edpa_pkg::OFF_TX_POLL,
               edpa_pkg::OFF_RX_POLL, edpa_pkg::OFF_STATUS,
               edpa_pkg::OFF_INT_MASK, edpa_pkg::OFF_CUR_TX,
               edpa_pkg::OFF_CUR_RX, edpa_pkg::OFF_DESC_CTL:
                  s_axi_bresp <= edpa_pkg::AXI_OKAY;
               default: s_axi_bresp <= edpa_pkg::AXI_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= edpa_pkg::AXI_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= edpa_pkg::AXI_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         unique case (s_axi_araddr)
            edpa_pkg::OFF_BUS_MODE: begin
               s_axi_rdata[edpa_pkg::BIT_SOFT_RESET] <= soft_reset_r;
               s_axi_rdata[edpa_pkg::BIT_ARB_SELECT] <=
                  mode_r.arbitration_select;
               s_axi_rdata[edpa_pkg::GAP_MSB:edpa_pkg::GAP_LSB] <=
                  mode_r.descriptor_gap_words;
               s_axi_rdata[edpa_pkg::RATIO_MSB:edpa_pkg::RATIO_LSB] <=
                  mode_r.rx_tx_weight_ratio;
               s_axi_rdata[edpa_pkg::BIT_TX_FIRST] <= mode_r.tx_first_bit;
            end
            // Poll registers read as zero
            edpa_pkg::OFF_TX_POLL: s_axi_rdata <= 32'h0000_0000;
            edpa_pkg::OFF_RX_POLL: s_axi_rdata <= 32'h0000_0000;
            edpa_pkg::OFF_STATUS: s_axi_rdata <= status_r;
            edpa_pkg::OFF_INT_MASK: s_axi_rdata <= mask_r;
            edpa_pkg::OFF_CUR_TX: s_axi_rdata <= current_tx_descriptor_ptr_r;
            edpa_pkg::OFF_CUR_RX: s_axi_rdata <= current_rx_descriptor_ptr_r;
            edpa_pkg::OFF_DESC_CTL: s_axi_rdata <= {30'h0, rx_ring_end_r,
               tx_ring_end_r};
            default: s_axi_rresp <= edpa_pkg::AXI_SLVERR;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Soft reset: held until counter expires and MAC reports idle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         soft_reset_r <= 1'b1;
         rst_cnt_r <= 5'h00;
      end else if (soft_reset_r) begin
         if (rst_cnt_r < 5'(edpa_pkg::RESET_CYC)) begin
            rst_cnt_r <= rst_cnt_r + 5'h01;
         end else if (!i_mac_reset_busy) begin
            soft_reset_r <= 1'b0;
         end
      end else if (wr_fire && awaddr_r == edpa_pkg::OFF_BUS_MODE &&
            wstrb_r[0] && wdata_r[edpa_pkg::BIT_SOFT_RESET]) begin
         soft_reset_r <= 1'b1;
         rst_cnt_r <= 5'h00;
      end
   end

   // Writes ignored while reset runs; software waits for the bit to clear
   always_ff @(posedge i_clk) begin
      if (dma_rst) begin
         mode_r <= '0;
         mask_r <= 32'h0000_0000;
         tx_base_r <= 32'h0000_0000;
         rx_base_r <= 32'h0000_0000;
         tx_ring_end_r <= 1'b0;
         rx_ring_end_r <= 1'b0;
      end else if (wr_fire) begin
         unique case (awaddr_r)
            edpa_pkg::OFF_BUS_MODE: begin
               if (wstrb_r[0]) begin
                  mode_r.arbitration_select <=
                     wdata_r[edpa_pkg::BIT_ARB_SELECT];
                  mode_r.descriptor_gap_words <=
                     wdata_r[edpa_pkg::GAP_MSB:edpa_pkg::GAP_LSB];
               end
               if (wstrb_r[1]) begin
                  mode_r.rx_tx_weight_ratio <=
                     wdata_r[edpa_pkg::RATIO_MSB:edpa_pkg::RATIO_LSB];
               end
               if (wstrb_r[3]) begin
                  mode_r.tx_first_bit <= wdata_r[edpa_pkg::BIT_TX_FIRST];
               end
            end
            edpa_pkg::OFF_INT_MASK: mask_r <= merge(mask_r, wdata_r,
               wstrb_r) & edpa_pkg::STATUS_MASK;
            edpa_pkg::OFF_CUR_TX: tx_base_r <= merge(tx_base_r, wdata_r,
               wstrb_r);
            edpa_pkg::OFF_CUR_RX: rx_base_r <= merge(rx_base_r, wdata_r,
               wstrb_r);
            edpa_pkg::OFF_DESC_CTL: begin
               if (wstrb_r[0]) begin
                  tx_ring_end_r <= wdata_r[0];
                  rx_ring_end_r <= wdata_r[1];
               end
            end
            default: ;
         endcase
      end
   end

   // Poll demand latches; dropped when the refetch is issued
   always_ff @(posedge i_clk) begin
      if (dma_rst) begin
         tx_poll_value_r <= 1'b0;
         rx_poll_value_r <= 1'b0;
      end else begin
         if (wr_fire && awaddr_r == edpa_pkg::OFF_TX_POLL) begin
            tx_poll_value_r <= 1'b1;
         end else if (tx_gnt) begin
            tx_poll_value_r <= 1'b0;
         end
         if (wr_fire && awaddr_r == edpa_pkg::OFF_RX_POLL) begin
            rx_poll_value_r <= 1'b1;
         end else if (rx_gnt) begin
            rx_poll_value_r <= 1'b0;
         end
      end
   end

   // Fetch requests: running paths after a descriptor, suspended on poll
   assign tx_req = !busy_r && ((tx_st_r == EDPA_SUSP && tx_poll_value_r)
      || tx_st_r == EDPA_FETCH);
   assign rx_req = !busy_r && ((rx_st_r == EDPA_SUSP && rx_poll_value_r)
      || rx_st_r == EDPA_FETCH);

   edpa_arbiter u_arb (
      .i_clk(i_clk),
      .i_srst(dma_rst),
      .i_mode(mode_r),
      .i_tx_req(tx_req),
      .i_rx_req(rx_req),
      .i_take(!busy_r),
      .o_tx_gnt(tx_gnt),
      .o_rx_gnt(rx_gnt)
   );

   // One fetch outstanding at a time
   always_ff @(posedge i_clk) begin
      if (dma_rst) begin
         busy_r <= 1'b0;
         busy_rx_r <= 1'b0;
         o_fetch <= '0;
      end else if (tx_gnt || rx_gnt) begin
         busy_r <= 1'b1;
         busy_rx_r <= rx_gnt;
         o_fetch.valid <= 1'b1;
         o_fetch.is_rx <= rx_gnt;
         o_fetch.addr <= rx_gnt ? current_rx_descriptor_ptr_r :
            current_tx_descriptor_ptr_r;
      end else begin
         o_fetch.valid <= 1'b0;
         if (i_fetch_ans.valid) begin
            busy_r <= 1'b0;
         end
      end
   end

   // Tx path state and pointer
   always_ff @(posedge i_clk) begin
      if (dma_rst) begin
         tx_st_r <= EDPA_SUSP;
         current_tx_descriptor_ptr_r <= 32'h0000_0000;
      end else if (wr_fire && awaddr_r == edpa_pkg::OFF_CUR_TX) begin
         current_tx_descriptor_ptr_r <= merge(current_tx_descriptor_ptr_r,
            wdata_r, wstrb_r);
      end else if (i_tx_underflow) begin
         tx_st_r <= EDPA_SUSP;
      end else if (busy_r && !busy_rx_r && i_fetch_ans.valid) begin
         tx_st_r <= i_fetch_ans.dma_owned ? EDPA_RUN : EDPA_SUSP;
      end else if (tx_st_r == EDPA_RUN && i_tx_desc_done) begin
         tx_st_r <= EDPA_FETCH;
         current_tx_descriptor_ptr_r <= next_desc(
            current_tx_descriptor_ptr_r, mode_r.descriptor_gap_words,
            1'b0, tx_ring_end_r, tx_base_r);
      end
   end

   // Rx path state and pointer
   always_ff @(posedge i_clk) begin
      if (dma_rst) begin
         rx_st_r <= EDPA_SUSP;
         current_rx_descriptor_ptr_r <= 32'h0000_0000;
      end else if (wr_fire && awaddr_r == edpa_pkg::OFF_CUR_RX) begin
         current_rx_descriptor_ptr_r <= merge(current_rx_descriptor_ptr_r,
            wdata_r, wstrb_r);
      end else if (busy_r && busy_rx_r && i_fetch_ans.valid) begin
         rx_st_r <= i_fetch_ans.dma_owned ? EDPA_RUN : EDPA_SUSP;
      end else if (rx_st_r == EDPA_RUN && i_rx_desc_done) begin
         rx_st_r <= EDPA_FETCH;
         current_rx_descriptor_ptr_r <= next_desc(
            current_rx_descriptor_ptr_r, mode_r.descriptor_gap_words,
            1'b0, rx_ring_end_r, rx_base_r);
      end
   end

   // Sticky status: set wins over read-clear
   always_comb begin
      set_bits = 32'h0000_0000;
      set_bits[edpa_pkg::BIT_TX_UNDERFLOW] = i_tx_underflow;
      set_bits[edpa_pkg::BIT_TX_BUF_UNAVAIL] = busy_r && !busy_rx_r &&
         i_fetch_ans.valid && !i_fetch_ans.dma_owned;
      set_bits[edpa_pkg::BIT_RX_BUF_UNAVAIL] = busy_r && busy_rx_r &&
         i_fetch_ans.valid && !i_fetch_ans.dma_owned;
   end

   always_ff @(posedge i_clk) begin
      if (dma_rst) begin
         status_r <= 32'h0000_0000;
      end else if (rd_fire && s_axi_araddr == edpa_pkg::OFF_STATUS) begin
         status_r <= set_bits;
      end else begin
         status_r <= status_r | set_bits;
      end
   end
endmodule

// ---- test/edpa_ctrl_monitor.sv ----
/*
 Checker on the ports of the poll/arbitration control block.
 Assumes: bound to edpa_ctrl; one clock, sync reset.
*/
`timescale 1ns/100ps
module edpa_ctrl_monitor (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Register bus
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   // Fetch link and status
   input wire edpa_pkg::edpa_fetch_t o_fetch,
   input wire edpa_pkg::edpa_fetch_ans_t i_fetch_ans,
   input wire logic i_mac_reset_busy,
   input wire logic o_dma_mac_reset,
   input wire logic o_irq
);
   logic [4:0] rst_cnt_r;
   logic wait_r;
   // Saturates so a long run cannot wrap back below the minimum
   always_ff @(posedge i_clk) begin
      if (i_srst || !o_dma_mac_reset) rst_cnt_r <= 5'h00;
      else if (rst_cnt_r != 5'h1f) rst_cnt_r <= rst_cnt_r + 5'h01;
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) wait_r <= 1'b0;
      else if (o_fetch.valid) wait_r <= 1'b1;
      else if (i_fetch_ans.valid) wait_r <= 1'b0;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   srst_sets_a: assert property (
      $fell(i_srst) |-> o_dma_mac_reset) else $error("reset bit low");
   reset_min_a: assert property (
      $fell(o_dma_mac_reset) |-> rst_cnt_r >= 5'h10)
      else $error("soft reset too short");
   busy_hold_a: assert property (
      o_dma_mac_reset && i_mac_reset_busy |=> o_dma_mac_reset)
      else $error("soft reset ended while mac busy");
   irq_quiet_a: assert property (
      o_dma_mac_reset && $past(o_dma_mac_reset) |-> !o_irq)
      else $error("irq during soft reset");
   txpoll_zero_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
      |=> s_axi_rvalid && s_axi_rdata == 32'h0) else $error("poll read");
   unmapped_err_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h60
      |=> s_axi_rresp == edpa_pkg::AXI_SLVERR) else $error("no slverr");
   bresp_once_a: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("double write response");
   rresp_once_a: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("double read response");
   fetch_single_a: assert property (
      o_fetch.valid |-> !wait_r ##1 !o_fetch.valid)
      else $error("fetch overlaps");
   cover property (o_fetch.valid && !o_fetch.is_rx);
   cover property (o_fetch.valid && o_fetch.is_rx);
   cover property ($rose(o_irq));
endmodule
bind edpa_ctrl edpa_ctrl_monitor edpa_ctrl_monitor_inst (.i_clk(i_clk),
   .i_srst(i_srst), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .o_fetch(o_fetch), .i_fetch_ans(i_fetch_ans),
   .i_mac_reset_busy(i_mac_reset_busy),
   .o_dma_mac_reset(o_dma_mac_reset), .o_irq(o_irq));

// ---- test/edpa_host_mem.sv ----
/*
 Host memory model answering descriptor fetches.
 Assumes: fetch requests are one-cycle pulses, one in flight.
*/
`timescale 1ns/100ps
module edpa_host_mem (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Behaviour controls
   input wire logic i_tx_owned,
   input wire logic i_rx_owned,
   input wire logic [7:0] i_delay,
   // Fetch link
   input wire edpa_pkg::edpa_fetch_t i_fetch,
   output edpa_pkg::edpa_fetch_ans_t o_ans,
   output logic o_busy
);
   logic [7:0] cnt_r;
   logic own_r;
   // Owner bit toggles outside answers so a stale value never passes
   always_ff @(posedge i_clk) begin
      o_ans.valid <= 1'b0;
      o_ans.dma_owned <= ~o_ans.dma_owned;
      o_ans.chained <= ~o_ans.chained;
      if (i_srst) begin
         o_busy <= 1'b0;
         o_ans.dma_owned <= 1'b0;
         o_ans.chained <= 1'b0;
      end else if (i_fetch.valid) begin
         o_busy <= 1'b1;
         cnt_r <= i_delay;
         own_r <= i_fetch.is_rx ? i_rx_owned : i_tx_owned;
      end else if (o_busy && cnt_r == 8'h00) begin
         o_busy <= 1'b0;
         o_ans.valid <= 1'b1;
         o_ans.dma_owned <= own_r;
      end else if (o_busy) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule

// ---- test/edpa_ctrl_tb_top.sv ----
/*
 Testbench for edpa_ctrl: AXI4-Lite tasks and directed tests.
 Assumes: edpa_host_mem answers fetches; checker bound separately.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
 $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module edpa_ctrl_tb_top;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, o_dma_mac_reset, o_irq, mem_busy;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   edpa_pkg::edpa_fetch_t o_fetch;
   edpa_pkg::edpa_fetch_ans_t i_fetch_ans;
   logic i_tx_underflow = 1'b0, i_tx_desc_done = 1'b0;
   logic i_rx_desc_done = 1'b0, i_mac_reset_busy = 1'b1;
   logic tx_owned = 1'b0, rx_owned = 1'b0;
   logic [7:0] delay = 8'h00;
   int failures = 0, compares = 0, cyc = 0;
   logic [32:0] fq[$];
   always #20 i_clk = ~i_clk;
   edpa_ctrl edpa_ctrl_inst (.i_clk, .i_srst, .s_axi_awvalid,
      .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .o_fetch,
      .i_fetch_ans, .i_tx_underflow, .i_tx_desc_done, .i_rx_desc_done,
      .i_mac_reset_busy, .o_dma_mac_reset, .o_irq);
   edpa_host_mem edpa_host_mem_inst (.i_clk, .i_srst, .i_tx_owned(tx_owned),
      .i_rx_owned(rx_owned), .i_delay(delay), .i_fetch(o_fetch),
      .o_ans(i_fetch_ans), .o_busy(mem_busy));
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Fetch log, plus a ceiling well above the few hundred cycles needed
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_fetch.valid) fq.push_back({o_fetch.is_rx, o_fetch.addr});
      if (cyc == 4000) begin
         failures++;
         $display("mismatch at %0t: timeout", $time);
         summarize;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit aw = 1'b1;
      bit w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge i_clk);
         if (s_axi_awready) aw = 1'b0;
         if (s_axi_wready) w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do @(posedge i_clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge i_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge i_clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic fetch_is(input logic [32:0] e);
      logic [32:0] f;
      while (fq.size() == 0) @(posedge i_clk);
      f = fq.pop_front();
      `CHK(f, e)
   endtask
   task automatic settle;
      do @(posedge i_clk); while (mem_busy);
      @(posedge i_clk);
   endtask
   task automatic tx_pulse(input bit uf);
      i_tx_underflow <= uf;
      i_tx_desc_done <= !uf;
      @(posedge i_clk);
      i_tx_underflow <= 1'b0;
      i_tx_desc_done <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge i_clk);
      i_srst <= 1'b0;
      rd(8'h00);
      `CHK(d[0], 1'b1)
      repeat (30) @(posedge i_clk);
      `CHK(o_dma_mac_reset, 1'b1)
      i_mac_reset_busy <= 1'b0;
      do rd(8'h00); while (d[0] !== 1'b0);
      @(posedge i_clk);
      `CHK(o_dma_mac_reset, 1'b0)
      $display("test reset done");
      wr(8'h1c, 32'h24);
      rd(8'h1c);
      `CHK(d, 32'h24)
      wr(8'h60, 32'h1);
      `CHK(r, edpa_pkg::AXI_SLVERR)
      rd(8'h60);
      `CHK({r, d}, {edpa_pkg::AXI_SLVERR, 32'h0})
      $display("test regmap done");
      wr(8'h48, 32'h1000);
      wr(8'h04, 32'hffffffff);
      fetch_is({1'b0, 32'h1000});
      settle;
      `CHK(o_irq, 1'b1)
      rd(8'h04);
      `CHK(d, 32'h0)
      rd(8'h14);
      `CHK(d, 32'h4)
      rd(8'h14);
      `CHK({o_irq, d}, 33'h0)
      // Rx unavailable is masked here, so the irq must stay low
      wr(8'h4c, 32'h2000);
      for (int i = 0; i < 2; i++) begin
         wr(8'h08, 32'h5);
         fetch_is({1'b1, 32'h2000});
         settle;
         `CHK(o_irq, 1'b0)
         rd(8'h14);
         `CHK(d, 32'h80)
      end
      $display("test poll done");
      tx_owned <= 1'b1;
      wr(8'h00, 32'h0c);
      wr(8'h04, 32'h0);
      fetch_is({1'b0, 32'h1000});
      settle;
      tx_pulse(1'b0);
      fetch_is({1'b0, 32'h101c});
      settle;
      wr(8'h00, 32'h0);
      tx_pulse(1'b0);
      fetch_is({1'b0, 32'h102c});
      settle;
      tx_pulse(1'b1);
      tx_owned <= 1'b0;
      rd(8'h14);
      `CHK(d, 32'h20)
      wr(8'h04, 32'h0);
      fetch_is({1'b0, 32'h102c});
      settle;
      rd(8'h14);
      `CHK(d, 32'h4)
      $display("test gap done");
      delay <= 8'h14;
      for (int tf = 0; tf < 2; tf++) begin
         wr(8'h00, {4'h0, tf[0], 25'h0, 2'h2});
         wr(8'h08, 32'h0);
         fetch_is({1'b1, 32'h2000});
         wr(8'h04, 32'h0);
         wr(8'h08, 32'h0);
         fetch_is(tf ? {1'b0, 32'h102c} : {1'b1, 32'h2000});
         fetch_is(tf ? {1'b1, 32'h2000} : {1'b0, 32'h102c});
         settle;
         rd(8'h14);
         `CHK(d, 32'h84)
      end
      $display("test priority done");
      wr(8'h00, 32'h1);
      `CHK(o_dma_mac_reset, 1'b1)
      do rd(8'h00); while (d[0] !== 1'b0);
      rd(8'h1c);
      `CHK(d, 32'h0)
      rd(8'h48);
      `CHK(d, 32'h0)
      // Round-robin 1:1 with rx favoured: rx, then tx, then rx again
      wr(8'h08, 32'h0);
      fetch_is({1'b1, 32'h0});
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h0);
      fetch_is({1'b0, 32'h0});
      fetch_is({1'b1, 32'h0});
      settle;
      $display("test soft reset and round robin done");
      summarize;
   end
endmodule
